/* common/output_driver_defines.vh */
`ifndef OUTPUT_DRIVER_DEFINES_VH
`define OUTPUT_DRIVER_DEFINES_VH

// ----------------------------------------------------------------
// register addresses: bit 7 is the page, bits 6..0 the register
// ----------------------------------------------------------------
`define ADDR_SW_RESET 8'h01
`define ADDR_FLAGS_A 8'h2d
`define ADDR_FLAGS_B 8'h2e
`define ADDR_STEP_CTRL 8'h3f
`define ADDR_REG_SEL 8'h82
`define ADDR_HP_PWR 8'h89
`define ADDR_HP_DRIVE 8'h8a
`define ADDR_HP_PROT 8'h8b
`define ADDR_ROUTE 8'h8c
`define ADDR_HP_GAIN 8'h90
`define ADDR_SPK_PWR 8'had
`define ADDR_SPK_VOL 8'hae
`define ADDR_SPK_GAIN 8'hb0
`define ADDR_STAGE_STAT 8'hbf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_SW_RESET 0
`define BIT_OT_FLAG 7
`define BIT_HP_SC_FLAG 5
`define BIT_SPK_SC_FLAG 7
`define BIT_HP_PWR 5
`define BIT_HP_HALF 2
`define BIT_HP_SC_MODE 1
`define BIT_ROUTE_SPK 3
`define BIT_HP_MUTE 6
`define BIT_SPK_PWR 1
`define BIT_HP_ON 7
`define BIT_SPK_ON 6
`define BIT_VOL_BUSY 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_STEP 2'h0
`define RST_REG_SEL 2'h0
`define RST_HP_GAIN 6'h00
`define RST_SPK_ATTEN 7'h7f
`define RST_SPK_GAIN 3'h0

// ----------------------------------------------------------------
// timing, clock period 8 ns
// ----------------------------------------------------------------
`define CLK_NS 8
`define STEP0_NS 1000
`define STEP1_NS 2000
`define STEP2_NS 500
`define SOFTSTART_NS 4000
`define STEP0_CYC ((`STEP0_NS + `CLK_NS - 1) / `CLK_NS)
`define STEP1_CYC ((`STEP1_NS + `CLK_NS - 1) / `CLK_NS)
`define STEP2_CYC ((`STEP2_NS + `CLK_NS - 1) / `CLK_NS)
`define SOFTSTART_CYC ((`SOFTSTART_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* core/output_driver_control_protect.v */
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "output_driver_defines.vh"

module output_driver_control_protect
(
    input wire clk,
    input wire srst,
    input wire [7:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    output reg [7:0] rdData,
    input wire hpShortDet,
    input wire spkShortDet,
    input wire overTemp,
    output reg hpEnable,
    output reg hpHalfDrive,
    output reg hpCurrentLimit,
    output reg [5:0] hpGain,
    output reg hpMute,
    output reg spkEnable,
    output reg spkSwitchEn,
    output reg [2:0] spkGain,
    output reg spkMute,
    output reg [6:0] spkAtten,
    output reg spkRoute,
    output reg [1:0] regulatorSelect
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // timing counts are whole integers; keep only the bits the counters hold
    localparam [31:0] STEP0_W = `STEP0_CYC;
    localparam [31:0] STEP1_W = `STEP1_CYC;
    localparam [31:0] STEP2_W = `STEP2_CYC;
    localparam [31:0] SOFTSTART_W = `SOFTSTART_CYC - 1;
    localparam [8:0] SOFTSTART_LAST = SOFTSTART_W[8:0];

    function [7:0] stepCycles;
        input [1:0] code;
        begin
            case (code)
                2'h0: stepCycles = STEP0_W[7:0];
                2'h1: stepCycles = STEP1_W[7:0];
                2'h2: stepCycles = STEP2_W[7:0];
                default: stepCycles = 8'h01;
            endcase
        end
    endfunction

    // write decode shared by the power bits and the software reset
    function wrTo;
        input stb;
        input [7:0] a;
        input [7:0] target;
        begin
            wrTo = stb && (a == target);
        end
    endfunction

    // a stage is up once its ramp counter has reached the last soft-start cycle
    function rampDone;
        input [8:0] cnt;
        begin
            rampDone = (cnt == SOFTSTART_LAST);
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [1:0] stepCode_r;
    reg [1:0] regSel_r;
    reg hpPwr_r;
    reg hpHalf_r;
    reg hpScMode_r;
    reg route_r;
    reg [5:0] hpGain_r;
    reg hpMute_r;
    reg spkPwr_r;
    reg [6:0] spkTarget_r;
    reg [2:0] spkGain_r;
    reg hpScFlag_r;
    reg spkScFlag_r;
    reg [6:0] spkCur_r;
    reg [7:0] stepCnt_r;
    reg [8:0] hpRamp_r;
    reg [8:0] spkRamp_r;
    reg hpOn_r;
    reg spkOn_r;
    reg swReset_r;
    reg [7:0] rdNxt;

    wire wrHit;
    wire hpPwrWr;
    wire spkPwrWr;
    wire hpTrip;
    wire spkTrip;
    wire volBusy;
    wire stepTick;

    assign wrHit = wrStb;
    assign hpPwrWr = wrTo(wrHit, addr, `ADDR_HP_PWR);
    assign spkPwrWr = wrTo(wrHit, addr, `ADDR_SPK_PWR);
    // short only counts against a stage that is powered
    assign hpTrip = hpShortDet && hpPwr_r && hpScMode_r;
    assign spkTrip = spkShortDet && spkPwr_r;
    assign volBusy = (spkCur_r != spkTarget_r);
    assign stepTick = (stepCnt_r == 8'h00);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst || swReset_r)
        begin
            stepCode_r <= `RST_STEP;
            regSel_r <= `RST_REG_SEL;
            hpPwr_r <= 1'b0;
            hpHalf_r <= 1'b0;
            hpScMode_r <= 1'b0;
            route_r <= 1'b0;
            hpGain_r <= `RST_HP_GAIN;
            hpMute_r <= 1'b1;
            spkPwr_r <= 1'b0;
            spkTarget_r <= `RST_SPK_ATTEN;
            spkGain_r <= `RST_SPK_GAIN;
            swReset_r <= 1'b0;
        end
        else
        begin
            // software reset is a one-cycle pulse that takes effect at the next edge
            swReset_r <= wrTo(wrHit, addr, `ADDR_SW_RESET) && wrData[`BIT_SW_RESET];
            if (wrHit)
            begin
                case (addr)
                    `ADDR_STEP_CTRL: stepCode_r <= wrData[1:0];
                    `ADDR_REG_SEL: regSel_r <= wrData[5:4];
                    `ADDR_HP_DRIVE: hpHalf_r <= wrData[`BIT_HP_HALF];
                    `ADDR_HP_PROT: hpScMode_r <= wrData[`BIT_HP_SC_MODE];
                    `ADDR_ROUTE: route_r <= wrData[`BIT_ROUTE_SPK];
                    `ADDR_HP_GAIN:
                    begin
                        hpGain_r <= wrData[5:0];
                        hpMute_r <= wrData[`BIT_HP_MUTE];
                    end
                    `ADDR_SPK_VOL: spkTarget_r <= wrData[6:0];
                    `ADDR_SPK_GAIN: spkGain_r <= wrData[6:4];
                    default: ;
                endcase
            end
            // protective shutdown beats a same-cycle rewrite of the power bit
            if (hpTrip)
                hpPwr_r <= 1'b0;
            else if (hpPwrWr)
                hpPwr_r <= wrData[`BIT_HP_PWR];
            if (spkTrip)
                spkPwr_r <= 1'b0;
            else if (spkPwrWr)
                spkPwr_r <= wrData[`BIT_SPK_PWR];
        end
    end

    // ------------------------------------------------------------
    // fault flags: sticky, cleared by rewriting the power bit to 1
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst || swReset_r)
        begin
            hpScFlag_r <= 1'b0;
            spkScFlag_r <= 1'b0;
        end
        else
        begin
            // a short on a powered stage in the cycle of a rewrite keeps the flag set
            if (hpShortDet && hpPwr_r)
                hpScFlag_r <= 1'b1;
            else if (hpPwrWr && wrData[`BIT_HP_PWR])
                hpScFlag_r <= 1'b0;
            if (spkShortDet && spkPwr_r)
                spkScFlag_r <= 1'b1;
            else if (spkPwrWr && wrData[`BIT_SPK_PWR])
                spkScFlag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // speaker volume soft-stepping
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst || swReset_r)
        begin
            spkCur_r <= `RST_SPK_ATTEN;
            stepCnt_r <= 8'h00;
        end
        // the pace counter reloads while idle, so a new target waits a full step
        else if (!volBusy)
        begin
            stepCnt_r <= stepCycles(stepCode_r) - 8'h01;
        end
        else if (stepTick)
        begin
            stepCnt_r <= stepCycles(stepCode_r) - 8'h01;
            if (spkCur_r < spkTarget_r)
                spkCur_r <= spkCur_r + 7'h01;
            else
                spkCur_r <= spkCur_r - 7'h01;
        end
        else
        begin
            stepCnt_r <= stepCnt_r - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // soft-start of each stage, independent of the other
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst || swReset_r)
        begin
            hpRamp_r <= 9'h000;
            spkRamp_r <= 9'h000;
            hpOn_r <= 1'b0;
            spkOn_r <= 1'b0;
        end
        else
        begin
            // dropping the power bit restarts the ramp from zero
            if (!hpPwr_r)
            begin
                hpRamp_r <= 9'h000;
                hpOn_r <= 1'b0;
            end
            else if (rampDone(hpRamp_r))
                hpOn_r <= 1'b1;
            else
                hpRamp_r <= hpRamp_r + 9'h001;
            if (!spkPwr_r)
            begin
                spkRamp_r <= 9'h000;
                spkOn_r <= 1'b0;
            end
            else if (rampDone(spkRamp_r))
                spkOn_r <= 1'b1;
            else
                spkRamp_r <= spkRamp_r + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (srst || swReset_r)
        begin
            hpEnable <= 1'b0;
            hpHalfDrive <= 1'b0;
            hpCurrentLimit <= 1'b0;
            hpGain <= `RST_HP_GAIN;
            hpMute <= 1'b1;
            spkEnable <= 1'b0;
            spkSwitchEn <= 1'b0;
            spkGain <= `RST_SPK_GAIN;
            spkMute <= 1'b1;
            spkAtten <= `RST_SPK_ATTEN;
            spkRoute <= 1'b0;
            regulatorSelect <= `RST_REG_SEL;
        end
        else
        begin
            // an enable drops at the very edge that sees a trip
            hpEnable <= hpOn_r && hpPwr_r && !hpTrip;
            hpHalfDrive <= hpHalf_r;
            hpCurrentLimit <= hpShortDet && hpPwr_r && !hpScMode_r;
            hpGain <= hpGain_r;
            hpMute <= hpMute_r;
            spkEnable <= spkOn_r && spkPwr_r && !spkTrip;
            // heat only stops switching; the stage stays powered and resumes when cool
            spkSwitchEn <= spkOn_r && spkPwr_r && !spkTrip && !overTemp;
            spkGain <= spkGain_r;
            spkMute <= (spkGain_r == 3'h0);
            spkAtten <= spkCur_r;
            spkRoute <= route_r;
            regulatorSelect <= regSel_r;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always @*
    begin
        // flags and status are live views; only the read data is registered
        rdNxt = 8'h00;
        case (addr)
            `ADDR_FLAGS_A:
            begin
                rdNxt[`BIT_OT_FLAG] = overTemp;
                rdNxt[`BIT_HP_SC_FLAG] = hpScFlag_r;
            end
            `ADDR_FLAGS_B: rdNxt[`BIT_SPK_SC_FLAG] = spkScFlag_r;
            `ADDR_STEP_CTRL: rdNxt[1:0] = stepCode_r;
            `ADDR_REG_SEL: rdNxt[5:4] = regSel_r;
            `ADDR_HP_PWR: rdNxt[`BIT_HP_PWR] = hpPwr_r;
            `ADDR_HP_DRIVE: rdNxt[`BIT_HP_HALF] = hpHalf_r;
            `ADDR_HP_PROT: rdNxt[`BIT_HP_SC_MODE] = hpScMode_r;
            `ADDR_ROUTE: rdNxt[`BIT_ROUTE_SPK] = route_r;
            `ADDR_HP_GAIN: rdNxt = {1'b0, hpMute_r, hpGain_r};
            `ADDR_SPK_PWR: rdNxt[`BIT_SPK_PWR] = spkPwr_r;
            `ADDR_SPK_VOL: rdNxt[6:0] = spkTarget_r;
            `ADDR_SPK_GAIN: rdNxt[6:4] = spkGain_r;
            `ADDR_STAGE_STAT:
            begin
                rdNxt[`BIT_HP_ON] = hpOn_r;
                rdNxt[`BIT_SPK_ON] = spkOn_r;
                rdNxt[`BIT_VOL_BUSY] = volBusy;
            end
            default: rdNxt = 8'h00;
        endcase
    end

    always @(posedge clk)
    begin
        // read data stand only in the cycle after the strobe
        if (srst)
            rdData <= 8'h00;
        else if (rdStb)
            rdData <= rdNxt;
        else
            rdData <= 8'h00;
    end

endmodule // output_driver_control_protect

`default_nettype wire

/* dv/driver_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module driver_checker
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [7:0] rdData,
    input wire logic hpShortDet,
    input wire logic spkShortDet,
    input wire logic overTemp,
    input wire logic hpEnable,
    input wire logic hpCurrentLimit,
    input wire logic spkEnable,
    input wire logic spkSwitchEn,
    input wire logic [2:0] spkGain,
    input wire logic spkMute,
    input wire logic [6:0] spkAtten
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------------------------------
    // power-up writes seen by the soft-start checks
    // ----------------------------------------------------------------
    wire logic spkOnWr = wrStb && addr == 8'had && wrData[1];
    wire logic hpOnWr = wrStb && addr == 8'h89 && wrData[5];
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_rd_idle; !$past(rdStb) |-> rdData == 8'h00; endproperty
    property p_rd_ot; rdStb && addr == 8'h2d |=> rdData[7] == $past(overTemp) && !rdData[6];
    endproperty
    property p_spk_soft; $rose(spkEnable) |-> $past(spkOnWr, 502); endproperty
    property p_hp_soft; $rose(hpEnable) |-> $past(hpOnWr, 502); endproperty
    property p_spk_trip; spkEnable && spkShortDet |-> ##[1:2] !spkEnable; endproperty
    property p_ot_stop; overTemp |=> !spkSwitchEn; endproperty
    property p_ot_run; (spkEnable && !overTemp) [*2] |-> spkSwitchEn; endproperty
    property p_limit; hpCurrentLimit |-> $past(hpShortDet); endproperty
    property p_spk_mute; spkMute == (spkGain == 3'h0); endproperty
    property p_step; $changed(spkAtten) |-> spkAtten == 7'h7f ||
        spkAtten - $past(spkAtten) == 7'h01 || $past(spkAtten) - spkAtten == 7'h01;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_rd_ot: assert property (p_rd_ot) else $error("flag read wrong");
    a_spk_soft: assert property (p_spk_soft) else $error("speaker ramp time");
    a_hp_soft: assert property (p_hp_soft) else $error("headphone ramp time");
    a_spk_trip: assert property (p_spk_trip) else $error("speaker not shut");
    a_ot_stop: assert property (p_ot_stop) else $error("switching while hot");
    a_ot_run: assert property (p_ot_run) else $error("switching not resumed");
    a_limit: assert property (p_limit) else $error("limit without short");
    a_spk_mute: assert property (p_spk_mute) else $error("speaker mute wrong");
    a_step: assert property (p_step) else $error("attenuation jumped");
    c_spk_on: cover property ($rose(spkEnable));
    c_limit: cover property (hpCurrentLimit);
    c_hot: cover property (overTemp && spkEnable);
endmodule // driver_checker
bind output_driver_control_protect driver_checker driver_checker_i (.clk, .srst, .addr,
    .wrData, .wrStb, .rdStb, .rdData, .hpShortDet, .spkShortDet, .overTemp, .hpEnable,
    .hpCurrentLimit, .spkEnable, .spkSwitchEn, .spkGain, .spkMute, .spkAtten);
`default_nettype wire

/* dv/load_model.sv */
`timescale 1ns/1ps
`default_nettype none
module load_model
(
    input wire logic clk,
    input wire logic hpShort,
    input wire logic spkShort,
    input wire logic heat,
    output logic hpShortDet,
    output logic spkShortDet,
    output logic overTemp
);
    // sensed conditions of the loads and die, held as levels
    always @(posedge clk)
    begin
        hpShortDet <= hpShort;
        spkShortDet <= spkShort;
        overTemp <= heat;
    end
endmodule // load_model
`default_nettype wire

/* dv/test_output_driver_control_protect.sv */
`timescale 1ns/1ps
`default_nettype none
module test_output_driver_control_protect;
    logic clk = 0, srst = 1, wrStb = 0, rdStb = 0, hpCmd = 0, spkCmd = 0, heatCmd = 0;
    logic [7:0] addr = 0, wrData = 0, rdData, d;
    logic hpShortDet, spkShortDet, overTemp, hpEnable, hpHalfDrive, hpCurrentLimit, hpMute;
    logic spkEnable, spkSwitchEn, spkMute, spkRoute;
    logic [5:0] hpGain;
    logic [2:0] spkGain;
    logic [6:0] spkAtten;
    logic [1:0] regulatorSelect;
    int fail_count = 0, n_checks = 0, cyc = 0;
    wire [14:0] obs = {hpHalfDrive, spkRoute, regulatorSelect, hpMute, hpGain, spkMute, spkGain};
    // rows: address, write data, readback, {half, route, regulator, mute, gain, mute, gain}
    logic [38:0] rows [15] = '{{8'h82, 8'h00, 8'h00, 15'h0408}, {8'h82, 8'h10, 8'h10, 15'h0c08},
        {8'h82, 8'h20, 8'h20, 15'h1408}, {8'h82, 8'h30, 8'h30, 15'h1c08},
        {8'h8a, 8'h04, 8'h04, 15'h5c08}, {8'h8c, 8'h08, 8'h08, 15'h7c08},
        {8'h90, 8'h7f, 8'h7f, 15'h7ff8}, {8'h90, 8'h15, 8'h15, 15'h7958},
        {8'hb0, 8'h70, 8'h70, 15'h7957}, {8'hb0, 8'h00, 8'h00, 15'h7958},
        {8'hb0, 8'h30, 8'h30, 15'h7953}, {8'h8b, 8'h02, 8'h02, 15'h7953},
        {8'h55, 8'hff, 8'h00, 15'h7953}, {8'h2e, 8'hff, 8'h00, 15'h7953},
        {8'h3f, 8'h03, 8'h03, 15'h7953}};
    always #4 clk = ~clk;
    output_driver_control_protect output_driver_control_protect_i (.clk(clk), .srst(srst),
        .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .hpShortDet(hpShortDet), .spkShortDet(spkShortDet), .overTemp(overTemp),
        .hpEnable(hpEnable), .hpHalfDrive(hpHalfDrive), .hpCurrentLimit(hpCurrentLimit),
        .hpGain(hpGain), .hpMute(hpMute), .spkEnable(spkEnable), .spkSwitchEn(spkSwitchEn),
        .spkGain(spkGain), .spkMute(spkMute), .spkAtten(spkAtten), .spkRoute(spkRoute),
        .regulatorSelect(regulatorSelect));
    load_model load_model_i (.clk(clk), .hpShort(hpCmd), .spkShort(spkCmd), .heat(heatCmd),
        .hpShortDet(hpShortDet), .spkShortDet(spkShortDet), .overTemp(overTemp));
    // ----------------------------------------------------------------
    // bus, compare and closing tasks
    // ----------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wrData <= v;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 v = rdData;
    endtask
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            end_of_test;
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        cycles(1);
        chk("resetOutputs", {hpEnable, spkEnable, hpMute, spkAtten}, 10'h0ff);
        rd(8'h8b, d);
        chk("hpShortMode", d, 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i][38:31], rows[i][30:23]);
            rd(rows[i][38:31], d);
            chk("readback", d, rows[i][22:15]);
            chk("outputs", obs, rows[i][14:0]);
        end
        wr(8'h8b, 8'h00);
        wr(8'had, 8'h02);
        repeat (600) if (spkEnable !== 1'b1) @(posedge clk);
        cycles(3);
        chk("spkOn", {spkEnable, spkSwitchEn}, 2'h3);
        rd(8'hbf, d);
        chk("stageStat", d & 8'hc0, 8'h40);
        heatCmd <= 1'b1;
        cycles(4);
        chk("spkSwitchEn", spkSwitchEn, 1'b0);
        rd(8'h2d, d);
        chk("otFlag", d, 8'h80);
        heatCmd <= 1'b0;
        cycles(4);
        chk("spkSwitchEn", spkSwitchEn, 1'b1);
        spkCmd <= 1'b1;
        cycles(4);
        chk("spkEnable", spkEnable, 1'b0);
        rd(8'h2e, d);
        chk("spkFlag", d, 8'h80);
        wr(8'had, 8'h02);
        cycles(4);
        rd(8'had, d);
        chk("spkPower", d, 8'h00);
        spkCmd <= 1'b0;
        cycles(2);
        wr(8'had, 8'h02);
        repeat (600) if (spkEnable !== 1'b1) @(posedge clk);
        cycles(1);
        chk("spkEnable", spkEnable, 1'b1);
        rd(8'h2e, d);
        chk("spkFlag", d, 8'h00);
        wr(8'h89, 8'h20);
        repeat (600) if (hpEnable !== 1'b1) @(posedge clk);
        hpCmd <= 1'b1;
        cycles(4);
        chk("hpLimit", {hpEnable, hpCurrentLimit, spkEnable}, 3'h7);
        rd(8'h2d, d);
        chk("hpFlag", d, 8'h20);
        wr(8'h8b, 8'h02);
        cycles(4);
        rd(8'h89, d);
        chk("hpPower", d, 8'h00);
        chk("hpEnable", hpEnable, 1'b0);
        hpCmd <= 1'b0;
        wr(8'hae, 8'h7c);
        cycles(10);
        chk("spkAtten", spkAtten, 7'h7c);
        wr(8'h3f, 8'h02);
        wr(8'hae, 8'h7a);
        cycles(40);
        chk("slowStep", spkAtten == 7'h7a, 1'b0);
        cycles(200);
        chk("spkAtten", spkAtten, 7'h7a);
        wr(8'h3f, 8'h01);
        wr(8'hae, 8'h7b);
        cycles(200);
        chk("slowStep", spkAtten, 7'h7a);
        cycles(100);
        chk("spkAtten", spkAtten, 7'h7b);
        wr(8'h01, 8'h01);
        cycles(3);
        chk("swReset", {spkEnable, regulatorSelect, hpMute, spkAtten}, 11'h0ff);
        wr(8'had, 8'h02);
        repeat (600) if (spkEnable !== 1'b1) @(posedge clk);
        cycles(1);
        chk("spkOn", spkEnable, 1'b1);
        wr(8'had, 8'h00);
        cycles(3);
        chk("spkOff", {spkEnable, spkSwitchEn}, 2'h0);
        end_of_test;
    end
endmodule // test_output_driver_control_protect
`default_nettype wire
